// [rtl/olsc_defines.svh]
// olsc_defines.svh: offsets, field positions, reset values and timing counts
// assumes byte offsets on a 32-bit register port and a 20 MHz mclk
`ifndef OLSC_DEFINES_SVH
`define OLSC_DEFINES_SVH
`define OLSC_OFF_LINE_SEL   8'h00
`define OLSC_OFF_OUT_CFG    8'h04
`define OLSC_OFF_SOFT_CMD   8'h08
`define OLSC_OFF_SNAPSHOT   8'h0C
`define OLSC_OFF_CTR_PICK   8'h10
`define OLSC_OFF_CTR_EN     8'h14
`define OLSC_OFF_CTR_TRIG   8'h18
`define OLSC_OFF_CTR_TARGET 8'h1C
`define OLSC_OFF_CTR_STATE  8'h20
`define OLSC_OFF_CTR_VALUE  8'h24
`define OLSC_OFF_CTR_START  8'h28
`define OLSC_OFF_IRQ_STAT   8'h2C
`define OLSC_OFF_IRQ_MASK   8'h30
`define OLSC_CFG_SRC_LSB    0
`define OLSC_CFG_SRC_MSB    1
`define OLSC_SRC_ILLEGAL    2'h3
`define OLSC_RST_ALL        '0
`define OLSC_CLK_NS         50
`define OLSC_TICK_NS        1000
`define OLSC_TICK_CYC       (`OLSC_TICK_NS / `OLSC_CLK_NS)
`define OLSC_PULSE_NS       10000
`define OLSC_PULSE_CYC      ((`OLSC_PULSE_NS + `OLSC_CLK_NS - 1) / `OLSC_CLK_NS)
`define OLSC_TICK_W         5
`define OLSC_PULSE_W        8
`endif

// [rtl/olsc_pkg.sv]
// olsc_pkg.sv: types of the output line and counter block
// assumes olsc_defines.svh is on the include path
package olsc_pkg;
	`include "olsc_defines.svh"
	typedef enum logic [1:0] {drive_low, software_driven, pulse_on_soft_command} olsc_src_t;
	typedef enum logic [1:0] {trig_off, trig_line1, trig_line2, trig_soft} olsc_trig_t;
	typedef enum logic [2:0] {ctr_idle, ctr_waiting, ctr_running, ctr_done, ctr_overflowed} olsc_ctr_state_t;
	typedef struct packed {
		logic      static_level_value;
		logic      soft_latch_select;
		olsc_src_t output_drive_source;
	} olsc_out_cfg_t;
	typedef struct packed {
		logic                      pin;
		logic [`OLSC_PULSE_W-1:0] pulse_left;
	} olsc_line_st_t;
	typedef struct packed {
		olsc_ctr_state_t state;
		logic [31:0]     value;
		logic            done_ev;
		logic            ovf_ev;
	} olsc_ctr_st_t;
endpackage

// [rtl/olsc_if.sv]
// olsc_if.sv: carriers between the top and its line and counter units
// assumes every end runs on mclk
`timescale 1ns/1ps
interface olsc_line_if import olsc_pkg::*; ();
	olsc_out_cfg_t cfg;
	logic          cmd;
	logic          pin;
	modport ctl  (output cfg, output cmd, input pin);
	modport unit (input cfg, input cmd, output pin);
endinterface // olsc_line_if

interface olsc_ctr_if import olsc_pkg::*; ();
	logic            enable;
	olsc_trig_t      trig;
	logic [31:0]     target;
	logic            start;
	logic            tick;
	olsc_ctr_state_t state;
	logic [31:0]     value;
	logic            done_ev;
	logic            ovf_ev;
	modport ctl  (output enable, trig, target, start, tick, input state, value, done_ev, ovf_ev);
	modport unit (input enable, trig, target, start, tick, output state, value, done_ev, ovf_ev);
endinterface // olsc_ctr_if

// [rtl/olsc_out_line.sv]
// olsc_out_line.sv: one output line driven statically, by latch or by pulse
// assumes cmd is a one-cycle pulse from the top
`timescale 1ns/1ps
`include "olsc_defines.svh"
module olsc_out_line import olsc_pkg::*; (
	// clock and reset
	input wire logic   mclk,
	input wire logic   rstn,
	// control side
	olsc_line_if.unit  l
);
	localparam logic [`OLSC_PULSE_W-1:0] PULSE_LAST = `OLSC_PULSE_W'(`OLSC_PULSE_CYC - 1);
	olsc_line_st_t q, d;

	always_comb begin
		d = q;
		unique case (l.cfg.output_drive_source)
			software_driven: begin
				d.pulse_left = '0;
				if (!l.cfg.soft_latch_select || l.cmd) begin
					d.pin = l.cfg.static_level_value;
				end
			end
			pulse_on_soft_command: begin
				if (l.cmd) begin
					d.pulse_left = PULSE_LAST;
					d.pin        = 1'b1;
				end else if (q.pulse_left != '0) begin
					d.pulse_left = q.pulse_left - 8'h01;
				end else begin
					d.pin = 1'b0;
				end
			end
			default: begin
				d.pin        = 1'b0;
				d.pulse_left = '0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			q <= `OLSC_RST_ALL;
		end else begin
			q <= d;
		end
	end

	assign l.pin = q.pin;
endmodule // olsc_out_line

// [rtl/olsc_counter.sv]
// olsc_counter.sv: one 32-bit duration counter with a five-state status
// assumes start and tick are one-cycle pulses
`timescale 1ns/1ps
module olsc_counter import olsc_pkg::*; (
	// clock and reset
	input wire logic  mclk,
	input wire logic  rstn,
	// control side
	olsc_ctr_if.unit  c
);
	olsc_ctr_st_t q, d;

	always_comb begin
		d         = q;
		d.done_ev = 1'b0;
		d.ovf_ev  = 1'b0;
		if (!c.enable || c.trig == trig_off) begin
			d.state = ctr_idle;
		end else begin
			unique case (q.state)
				ctr_idle: d.state = ctr_waiting;
				ctr_waiting: begin
					if (c.start) begin
						d.state = ctr_running;
						d.value = 32'h0;
					end
				end
				ctr_running: begin
					if (q.value == 32'hFFFFFFFF) begin
						d.state  = ctr_overflowed;
						d.ovf_ev = 1'b1;
					end else if (q.value == c.target) begin
						d.state   = ctr_done;
						d.done_ev = 1'b1;
					end else if (c.tick) begin
						d.value = q.value + 32'h1;
					end
				end
				ctr_done, ctr_overflowed: d.state = q.state;
				default: d.state = ctr_idle;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign c.state   = q.state;
	assign c.value   = q.value;
	assign c.done_ev = q.done_ev;
	assign c.ovf_ev  = q.ovf_ev;
endmodule // olsc_counter

// [rtl/olsc_top.sv]
// olsc_top.sv: software-driven output lines, all-lines snapshot, two counters
// assumes one 20 MHz mclk, synchronous line inputs and a one-cycle register port
//
// Contract
// - latch off: the output follows the stored static level directly.
// - latch mode: the output pin changes only on a command bit.
// - snapshot read returns every line level now, line 1 in bit 0.
// - any command value accepted; each one bit commands its output, several at once.
// - command bit 0 is output 1 (line 3), bit 1 output 2, upward.
// - on command: latched outputs take static level, pulse outputs fire.
// - commands reach only software-controlled outputs; other sources ignore them.
// - two counters; a pick setting routes counter config and status accesses.
// - counter enable setting: off disables, active enables the picked counter.
// - counter reconfiguration only while disabled; software disables first.
// - counter state is idle while the trigger choice is off.
// - enabled, trigger chosen, no start yet: state is waiting.
// - after its start trigger the counter reports running while counting.
// - count reaching target stops counting and shows done.
// - count reaching its largest value shows overflowed.
// - a started counter counts up from zero toward the target.
// - active static level closes the output circuit, inactive opens it.
`timescale 1ns/1ps
`include "olsc_defines.svh"
module olsc_top import olsc_pkg::*; (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// lines 1-2 are inputs, lines 3-6 are outputs 1-4
	input  wire logic [1:0]  gpi_level,
	output logic      [3:0]  out_close,
	// interrupt
	output logic             irq
);
	localparam logic [`OLSC_TICK_W-1:0] TICK_LAST = `OLSC_TICK_W'(`OLSC_TICK_CYC - 1);

	typedef struct packed {
		logic [1:0]                 line_sel;
		olsc_out_cfg_t [3:0]        cfg;
		logic                       counter_pick;
		logic [1:0]                 counter_enable_setting;
		olsc_trig_t [1:0]           counter_trigger_choice;
		logic [1:0][31:0]           counter_target;
		logic [5:0]                 irq_stat;
		logic [5:0]                 irq_mask;
		logic [31:0]                rdata;
		logic [`OLSC_TICK_W-1:0]    tick_cnt;
		logic                       tick;
		logic [1:0]                 gpi_prev;
	} olsc_top_st_t;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		return addr == off;
	endfunction

	function automatic logic [31:0] pick_word(input logic p, input logic [31:0] w0, input logic [31:0] w1);
		return p ? w1 : w0;
	endfunction

	olsc_top_st_t    q;
	olsc_top_st_t    d;
	logic            p;
	logic [3:0]      soft_command_bits;
	logic [3:0]      pins;
	logic [3:0]      pulse_mask;
	logic [1:0]      start;
	logic [1:0]      rise;
	logic [1:0]      done_ev;
	logic [1:0]      ovf_ev;
	logic [5:0]      w1c;
	olsc_ctr_state_t cst [2];
	logic [31:0]     cval [2];
	logic [31:0]     pick_state;
	logic [31:0]     pick_value;

	olsc_line_if line_if [4] ();
	olsc_ctr_if  ctr_if [2] ();

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	// output units, bit i of the command is output i+1
	for (genvar i = 0; i < 4; i++) begin : g_line
		assign line_if[i].cmd = soft_command_bits[i];
		assign line_if[i].cfg = q.cfg[i];
		assign pins[i]        = line_if[i].pin;
		assign pulse_mask[i]  = q.cfg[i].output_drive_source == pulse_on_soft_command;

		olsc_out_line u_line (
			.mclk (mclk),
			.rstn (rstn),
			.l    (line_if[i])
		);

		sequence latch_idle;
			q.cfg[i].output_drive_source == software_driven && q.cfg[i].soft_latch_select
				&& !soft_command_bits[i];
		endsequence

		sequence low_src;
			q.cfg[i].output_drive_source == drive_low;
		endsequence

		level_follow_a: assert property (
			q.cfg[i].output_drive_source == software_driven && !q.cfg[i].soft_latch_select
				|=> pins[i] == $past(q.cfg[i].static_level_value)
		) else $error("static output does not follow its level");

		latch_hold_a: assert property (
			latch_idle |=> pins[i] == $past(pins[i])
		) else $error("latched output moved without a command");

		pulse_fire_a: assert property (
			q.cfg[i].output_drive_source == pulse_on_soft_command && soft_command_bits[i]
				|=> pins[i] [*8]
		) else $error("commanded pulse missing");

		low_ignore_a: assert property (
			low_src ##1 low_src |-> !pins[i]
		) else $error("non-software output driven");
	end

	// counter units
	for (genvar i = 0; i < 2; i++) begin : g_ctr
		assign ctr_if[i].enable = q.counter_enable_setting[i];
		assign ctr_if[i].trig   = q.counter_trigger_choice[i];
		assign ctr_if[i].target = q.counter_target[i];
		assign ctr_if[i].start  = start[i];
		assign ctr_if[i].tick   = q.tick;
		assign cst[i]           = ctr_if[i].state;
		assign cval[i]          = ctr_if[i].value;
		assign done_ev[i]       = ctr_if[i].done_ev;
		assign ovf_ev[i]        = ctr_if[i].ovf_ev;

		olsc_counter u_ctr (
			.mclk (mclk),
			.rstn (rstn),
			.c    (ctr_if[i])
		);

		sequence armed;
			q.counter_enable_setting[i] && q.counter_trigger_choice[i] != trig_off;
		endsequence

		sequence armed_start;
			armed ##0 (cst[i] == ctr_waiting && start[i]);
		endsequence

		trig_idle_a: assert property (
			q.counter_trigger_choice[i] == trig_off |=> cst[i] == ctr_idle
		) else $error("counter not idle with trigger off");

		arm_wait_a: assert property (
			armed ##0 (cst[i] == ctr_idle) |=> cst[i] == ctr_waiting
		) else $error("armed counter not waiting");

		start_run_a: assert property (
			armed_start |=> cst[i] == ctr_running && cval[i] == 32'h0
		) else $error("counter did not start from zero");

		reach_done_a: assert property (
			armed ##0 (cst[i] == ctr_running && cval[i] == q.counter_target[i] && cval[i] != 32'hFFFFFFFF)
				|=> cst[i] == ctr_done && done_ev[i] ##1 cval[i] == $past(cval[i], 2)
		) else $error("counter missed its target");

		reach_ovf_a: assert property (
			armed ##0 (cst[i] == ctr_running && cval[i] == 32'hFFFFFFFF) |=> cst[i] == ctr_overflowed
		) else $error("counter missed overflow");
	end

	assign pick_state = pick_word(p, 32'(cst[0]), 32'(cst[1]));
	assign pick_value = pick_word(p, cval[0], cval[1]);

	always_comb begin
		d          = q;
		p          = q.counter_pick;
		rise       = gpi_level & ~q.gpi_prev;
		d.gpi_prev = gpi_level;

		// microsecond tick sets the counting rate
		d.tick     = q.tick_cnt == TICK_LAST;
		d.tick_cnt = d.tick ? '0 : q.tick_cnt + 5'h01;

		soft_command_bits = (reg_wr && hit(reg_addr, `OLSC_OFF_SOFT_CMD)) ? reg_wdata[3:0] : 4'h0;

		// start source of each counter
		for (int c = 0; c < 2; c++) begin
			unique case (q.counter_trigger_choice[c])
				trig_off:   start[c] = 1'b0;
				trig_line1: start[c] = rise[0];
				trig_line2: start[c] = rise[1];
				trig_soft:  start[c] = reg_wr && hit(reg_addr, `OLSC_OFF_CTR_START)
					&& (p == c[0]) && reg_wdata[0];
			endcase
		end

		if (reg_wr) begin
			case (reg_addr)
				`OLSC_OFF_LINE_SEL: d.line_sel = reg_wdata[1:0];
				`OLSC_OFF_OUT_CFG: begin
					// an illegal source code would leave the line undefined, so drop it
					if (reg_wdata[`OLSC_CFG_SRC_MSB:`OLSC_CFG_SRC_LSB] != `OLSC_SRC_ILLEGAL) begin
						d.cfg[q.line_sel] = olsc_out_cfg_t'(reg_wdata[3:0]);
					end
				end
				`OLSC_OFF_CTR_PICK: d.counter_pick = reg_wdata[0];
				`OLSC_OFF_CTR_EN: d.counter_enable_setting[p] = reg_wdata[0];
				`OLSC_OFF_CTR_TRIG: begin
					if (!q.counter_enable_setting[p]) begin
						d.counter_trigger_choice[p] = olsc_trig_t'(reg_wdata[1:0]);
					end
				end
				`OLSC_OFF_CTR_TARGET: begin
					if (!q.counter_enable_setting[p]) begin
						d.counter_target[p] = reg_wdata;
					end
				end
				`OLSC_OFF_IRQ_MASK: d.irq_mask = reg_wdata[5:0];
				default: ;
			endcase
		end

		// a new event on the clearing edge survives the clear
		w1c        = (reg_wr && hit(reg_addr, `OLSC_OFF_IRQ_STAT)) ? reg_wdata[5:0] : 6'h00;
		d.irq_stat = (q.irq_stat & ~w1c) | {rise, ovf_ev, done_ev};

		d.rdata = 32'h0;
		if (reg_rd) begin
			case (reg_addr)
				`OLSC_OFF_LINE_SEL:   d.rdata = {30'h0, q.line_sel};
				`OLSC_OFF_OUT_CFG:    d.rdata = {28'h0, q.cfg[q.line_sel]};
				`OLSC_OFF_SNAPSHOT:   d.rdata = {26'h0, pins, gpi_level};
				`OLSC_OFF_CTR_PICK:   d.rdata = {31'h0, p};
				`OLSC_OFF_CTR_EN:     d.rdata = {31'h0, q.counter_enable_setting[p]};
				`OLSC_OFF_CTR_TRIG:   d.rdata = {30'h0, q.counter_trigger_choice[p]};
				`OLSC_OFF_CTR_TARGET: d.rdata = q.counter_target[p];
				`OLSC_OFF_CTR_STATE:  d.rdata = pick_state;
				`OLSC_OFF_CTR_VALUE:  d.rdata = pick_value;
				`OLSC_OFF_IRQ_STAT:   d.rdata = {26'h0, q.irq_stat};
				`OLSC_OFF_IRQ_MASK:   d.rdata = {26'h0, q.irq_mask};
				// command, start and unmapped words read zero
				default:              d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			q <= `OLSC_RST_ALL;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign out_close = pins;
	assign irq       = |(q.irq_stat & q.irq_mask);

	snapshot_read_a: assert property (
		reg_rd && hit(reg_addr, `OLSC_OFF_SNAPSHOT)
			|=> reg_rdata == {26'h0, $past(pins), $past(gpi_level)}
	) else $error("snapshot does not match line levels");

	cmd_empty_a: assert property (
		reg_rd && hit(reg_addr, `OLSC_OFF_SOFT_CMD) |=> reg_rdata == 32'h0
	) else $error("command word read back nonzero");

	cmd_multi_a: assert property (
		reg_wr && hit(reg_addr, `OLSC_OFF_SOFT_CMD)
			|=> (out_close & $past(pulse_mask & reg_wdata[3:0])) == $past(pulse_mask & reg_wdata[3:0])
	) else $error("commanded outputs did not all fire");

	target_lock_a: assert property (
		reg_wr && hit(reg_addr, `OLSC_OFF_CTR_TARGET) && q.counter_enable_setting[p]
			|=> $stable(q.counter_target)
	) else $error("target changed while counter enabled");

	pick_state_a: assert property (
		reg_rd && hit(reg_addr, `OLSC_OFF_CTR_STATE) |=> reg_rdata == $past(pick_state)
	) else $error("state read ignores the counter pick");

	done_sticky_a: assert property (
		done_ev[0] |=> q.irq_stat[0] ##1 (q.irq_stat[0] || $past(w1c[0]))
	) else $error("done event lost from status");

	// sticky status keeps the line up until software clears or masks it
	irq_level_a: assert property (
		irq && !(reg_wr && (hit(reg_addr, `OLSC_OFF_IRQ_STAT) || hit(reg_addr, `OLSC_OFF_IRQ_MASK))) |=> irq
	) else $error("interrupt dropped without a clear");
endmodule // olsc_top

// [bench/olsc_line_equip.sv]
// olsc_line_equip.sv: external equipment wired to the camera i/o lines
// assumes the bench calls drive() to change input levels, one edge at a time
`timescale 1ns/1ps
module olsc_line_equip (
	// clock
	input  wire logic       mclk,
	// lines
	input  wire logic [3:0] out_close,
	output logic      [1:0] gpi_level
);
	int closures [4] = '{0, 0, 0, 0};
	initial gpi_level <= 2'b00;
	// levels move just after an edge, like a synchronised source
	task automatic drive(input logic [1:0] v);
		@(posedge mclk);
		gpi_level <= v;
	endtask
	// load side only counts closed cycles per output; it never loads the outputs back
	always @(posedge mclk) begin
		for (int i = 0; i < 4; i++) begin
			if (out_close[i])
				closures[i] <= closures[i] + 1;
		end
	end
endmodule // olsc_line_equip

// [bench/tb_top.sv]
// tb_top.sv: self-checking bench of olsc_top against a behavioural model
// assumes the olsc rtl files and olsc_line_equip are compiled before it
`timescale 1ns/1ps
`include "olsc_defines.svh"
module tb_top import olsc_pkg::*;;
	logic        mclk      = 1'b0;
	logic        rstn      = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [31:0] reg_rdata;
	logic [1:0]  gpi_level;
	logic [3:0]  out_close;
	logic        irq;
	logic [7:0]  seed      = 8'h43;
	int          fail_count = 0;
	int          tests_run  = 0;
	int          n;
	int          c0;
	int          m_src[4];
	int          m_lat[4];
	int          m_lvl[4];
	int          m_out[4];
	int          cmd_q[$] = '{15, 0, 1, 2};

	initial begin
		forever #25 mclk = ~mclk;
	end

	olsc_top dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpi_level(gpi_level), .out_close(out_close), .irq(irq));
	olsc_line_equip equip (.mclk(mclk), .out_close(out_close), .gpi_level(gpi_level));

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [3:0] model_outs();
		return {m_out[3][0], m_out[2][0], m_out[1][0], m_out[0][0]};
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(what, exp, d);
	endtask

	task automatic set_out(input int i, input int src, input int lat, input int lvl);
		wr(`OLSC_OFF_LINE_SEL, 32'(i));
		wr(`OLSC_OFF_OUT_CFG, 32'((lvl << 3) | (lat << 2) | src));
		m_src[i] = src;
		m_lat[i] = lat;
		m_lvl[i] = lvl;
		if (src == 0)
			m_out[i] = 0;
		else if (src == 1 && lat == 0)
			m_out[i] = lvl;
	endtask

	task automatic chk_outs();
		@(posedge mclk);
		#1;
		chk("out_close", {28'h0, model_outs()}, {28'h0, out_close});
	endtask

	task automatic soft_cmd(input logic [3:0] bits);
		wr(`OLSC_OFF_SOFT_CMD, {28'h0, bits});
		for (int i = 0; i < 4; i++) begin
			if (bits[i] && m_src[i] == 1 && m_lat[i] == 1)
				m_out[i] = m_lvl[i];
		end
	endtask

	task automatic wait_state(input logic [31:0] want, input int tries);
		logic [31:0] d;
		for (int t = 0; t < tries; t++) begin
			rd(`OLSC_OFF_CTR_STATE, d);
			if (d === want)
				break;
		end
		chk("ctr_state", want, d);
	endtask

	task automatic chk_irq(input logic exp);
		#1;
		chk("irq", {31'h0, exp}, {31'h0, irq});
	endtask

	task automatic finish_test();
		$display("compares %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		$display("[ERR] watchdog expected finish seen hang");
		finish_test();
	end

	initial begin
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rd_chk("snapshot", `OLSC_OFF_SNAPSHOT, 32'h0);
		rd_chk("ctr_state", `OLSC_OFF_CTR_STATE, 32'(ctr_idle));
		rd_chk("unmapped", 8'h3C, 32'h0);
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			seed = lfsr_next(seed);
			set_out(k % 4, 1, 0, int'(seed[0]));
			chk_outs();
		end
		$display("test static levels done");
		set_out(0, 1, 1, 1);
		set_out(1, 1, 1, 0);
		set_out(2, 0, 0, 1);
		set_out(3, 1, 0, 1);
		chk_outs();
		for (int k = 0; k < 6; k++) begin
			seed = lfsr_next(seed);
			cmd_q.push_back(int'(seed[3:0]));
		end
		while (cmd_q.size() > 0) begin
			soft_cmd(4'(cmd_q.pop_front()));
			chk_outs();
			seed = lfsr_next(seed);
			set_out(seed[4] ? 0 : 1, 1, 1, int'(seed[5]));
			chk_outs();
		end
		wr(`OLSC_OFF_LINE_SEL, 32'h2);
		wr(`OLSC_OFF_OUT_CFG, 32'h0000000F);
		soft_cmd(4'h4);
		chk_outs();
		rd_chk("soft_cmd", `OLSC_OFF_SOFT_CMD, 32'h0);
		$display("test soft commands done");
		set_out(1, 0, 0, 0);
		set_out(1, 2, 0, 0);
		soft_cmd(4'h2);
		c0 = equip.closures[1];
		n = 0;
		#1;
		repeat (260) begin
			if (out_close[1] === 1'b1)
				n++;
			@(posedge mclk);
			#1;
		end
		chk("pulse_cycles", 32'(`OLSC_PULSE_CYC), 32'(n));
		chk("closed_cycles", 32'(`OLSC_PULSE_CYC), 32'(equip.closures[1] - c0));
		chk_outs();
		$display("test pulse done");
		for (int k = 0; k < 4; k++) begin
			seed = lfsr_next(seed);
			equip.drive(seed[1:0]);
			rd_chk("snapshot", `OLSC_OFF_SNAPSHOT, {26'h0, model_outs(), seed[1:0]});
		end
		$display("test snapshot done");
		equip.drive(2'b00);
		wr(`OLSC_OFF_IRQ_STAT, 32'h3F);
		rd_chk("irq_stat", `OLSC_OFF_IRQ_STAT, 32'h0);
		wr(`OLSC_OFF_CTR_PICK, 32'h0);
		wr(`OLSC_OFF_CTR_EN, 32'h1);
		rd_chk("ctr_state", `OLSC_OFF_CTR_STATE, 32'(ctr_idle));
		wr(`OLSC_OFF_CTR_EN, 32'h0);
		wr(`OLSC_OFF_CTR_TRIG, 32'(trig_soft));
		wr(`OLSC_OFF_CTR_TARGET, 32'h2);
		wr(`OLSC_OFF_CTR_EN, 32'h1);
		rd_chk("ctr_state", `OLSC_OFF_CTR_STATE, 32'(ctr_waiting));
		wr(`OLSC_OFF_CTR_TARGET, 32'h3E8);
		wr(`OLSC_OFF_CTR_START, 32'h1);
		rd_chk("ctr_state", `OLSC_OFF_CTR_STATE, 32'(ctr_running));
		wait_state(32'(ctr_done), 200);
		repeat (60) @(posedge mclk);
		rd_chk("ctr_value", `OLSC_OFF_CTR_VALUE, 32'h2);
		wr(`OLSC_OFF_CTR_PICK, 32'h1);
		rd_chk("ctr_state", `OLSC_OFF_CTR_STATE, 32'(ctr_idle));
		wr(`OLSC_OFF_CTR_TRIG, 32'(trig_line1));
		wr(`OLSC_OFF_CTR_TARGET, 32'h0);
		wr(`OLSC_OFF_CTR_EN, 32'h1);
		rd_chk("ctr_state", `OLSC_OFF_CTR_STATE, 32'(ctr_waiting));
		equip.drive(2'b01);
		wait_state(32'(ctr_done), 40);
		wr(`OLSC_OFF_CTR_PICK, 32'h0);
		rd_chk("ctr_state", `OLSC_OFF_CTR_STATE, 32'(ctr_done));
		wr(`OLSC_OFF_CTR_EN, 32'h0);
		rd_chk("ctr_state", `OLSC_OFF_CTR_STATE, 32'(ctr_idle));
		wr(`OLSC_OFF_CTR_EN, 32'h1);
		rd_chk("ctr_state", `OLSC_OFF_CTR_STATE, 32'(ctr_waiting));
		$display("test counters done");
		rd_chk("irq_stat", `OLSC_OFF_IRQ_STAT, 32'h13);
		chk_irq(1'b0);
		wr(`OLSC_OFF_IRQ_MASK, 32'h01);
		chk_irq(1'b1);
		wr(`OLSC_OFF_IRQ_STAT, 32'h01);
		chk_irq(1'b0);
		wr(`OLSC_OFF_IRQ_MASK, 32'h3F);
		chk_irq(1'b1);
		wr(`OLSC_OFF_IRQ_STAT, 32'h3F);
		chk_irq(1'b0);
		rd_chk("irq_stat", `OLSC_OFF_IRQ_STAT, 32'h0);
		$display("test interrupt done");
		wr(`OLSC_OFF_CTR_PICK, 32'h1);
		wr(`OLSC_OFF_CTR_EN, 32'h0);
		wr(`OLSC_OFF_CTR_TRIG, 32'(trig_line2));
		wr(`OLSC_OFF_CTR_TARGET, 32'h1);
		wr(`OLSC_OFF_CTR_EN, 32'h1);
		rd_chk("ctr_state", `OLSC_OFF_CTR_STATE, 32'(ctr_waiting));
		equip.drive(2'b11);
		wait_state(32'(ctr_done), 60);
		rd_chk("ctr_value", `OLSC_OFF_CTR_VALUE, 32'h1);
		rd_chk("irq_stat", `OLSC_OFF_IRQ_STAT, 32'h22);
		$display("test line2 trigger done");
		finish_test();
	end
endmodule // tb_top
